// ==== crao_pkg.sv ====
// Package: constants and bus carrier types for the command/address output stage
package crao_pkg;

  // ****************************************************************
  // Field widths
  // ****************************************************************
  localparam int CRAO_RANK_W = 4;
  localparam int CRAO_ADDR_W = 18;
  localparam int CRAO_BANK_W = 2;
  localparam int CRAO_BG_W   = 2;
  localparam int CRAO_CKE_W  = 2;
  localparam int CRAO_ODT_W  = 2;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int CRAO_WRITE_STROBE_BIT  = 14;    // Write strobe during activate
  localparam int CRAO_COLUMN_STROBE_BIT = 15;    // Column strobe during activate
  localparam int CRAO_ROW_STROBE_BIT    = 16;    // Row strobe during activate
  localparam int CRAO_CHIP_ID_LSB       = 2;     // Rank selects 2..3 carry chip id 0..1
  localparam int CRAO_LATENCY_DEF       = 1;     // Cycles from capture to valid output
  localparam int CRAO_LATENCY_MAX       = 8;
  localparam logic [CRAO_RANK_W-1:0] CRAO_RANK_IDLE = 4'hf;

  // ****************************************************************
  // Carrier of one command/address/control word
  // ****************************************************************
  typedef struct packed {
    logic [CRAO_RANK_W-1:0] rank_select_n;   // Active-low rank selects (or chip id bits 0..1)
    logic                   chip_id2;        // Chip identifier bit 2
    logic [CRAO_ADDR_W-1:0] addr;            // Bits 14..16 are strobes during activate
    logic [CRAO_BANK_W-1:0] bank;
    logic [CRAO_BG_W-1:0]   bank_group;
    logic                   activate_n;
    logic [CRAO_CKE_W-1:0]  clock_enable;
    logic [CRAO_ODT_W-1:0]  termination;
    logic                   parity;
  } crao_ca_t;

  localparam crao_ca_t CRAO_CA_RESET = '{
    rank_select_n: CRAO_RANK_IDLE,
    chip_id2:      1'b0,
    addr:          18'h00000,
    bank:          2'h0,
    bank_group:    2'h0,
    activate_n:    1'b1,
    clock_enable:  2'h0,
    termination:   2'h0,
    parity:        1'b0
  };

endpackage

// ==== crao_output_stage.sv ====
// Module: re-driving output stage of a registering command/address buffer
`timescale 1ns/1ps
// Function
// R1 - Valid command drives exactly one select low
// R2 - Activate: address bits 14-16 carry strobes
// R3 - Enabled parity error pulls alert low
// R4 - Error input pulls alert low always; the code releases alert while the reset input is low
// R5 - Re-driven reset comes from a flip-flop
// R6 - Outputs valid configured cycles after capture
// R7 - Upper selects carry chip id in mode
// R8 - Controller keeps even parity on inputs
// R9 - Low error input gives low alert
// R10 - Reset input clears latches, floats outputs
// R11 - Both output copies identical in value, timing
module crao_output_stage
  import crao_pkg::*;
#(
  parameter int LATENCY = CRAO_LATENCY_DEF
)
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Mode straps
  input  wire logic parity_enable,
  input  wire logic chip_id_mode,
  // Captured input side
  input  wire crao_ca_t ca_in,
  input  wire logic     module_reset_input_n,
  input  wire logic     error_in_n,
  // Re-driven copies
  output crao_ca_t      side_a_bus,
  output crao_ca_t      side_b_bus,
  output logic          bus_drive_en,
  output logic          redriven_module_reset_n,
  // Open-drain alert
  output logic          alert_out,
  output logic          alert_oe
);

  // ****************************************************************
  // Parameter check
  // ****************************************************************
  if (LATENCY < 1 || LATENCY > CRAO_LATENCY_MAX)
  begin : g_bad_latency
    $error("LATENCY must lie between 1 and 8");
  end

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    crao_ca_t [LATENCY-1:0] pipe;
    logic                   drive_en;
    logic                   rst_out_n;
    logic                   alert_oe;
  } crao_state_t;

  crao_state_t state_ff;
  crao_state_t nxt_state;

  // Exactly one active-low select among those in use
  function automatic logic crao_cmd_valid(input logic [CRAO_RANK_W-1:0] sel_n, input logic id_mode);
    logic v;
    v = id_mode ? $onehot(~sel_n[CRAO_CHIP_ID_LSB-1:0]) : $onehot(~sel_n);
    return v;
  endfunction

  // Even parity over address, bank, group, activate and parity pin
  function automatic logic crao_parity_bad(input crao_ca_t w);
    logic p;
    p = ^{w.addr, w.bank, w.bank_group, w.activate_n, w.parity};
    return p;
  endfunction

  logic     in_valid;
  logic     in_par_bad;
  crao_ca_t captured;

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb
  begin
    in_valid   = crao_cmd_valid(ca_in.rank_select_n, chip_id_mode);
    in_par_bad = crao_parity_bad(ca_in);
    captured   = ca_in;                                  // Strobes ride on bits 14..16 [R2]
    if (!in_valid)
    begin
      if (chip_id_mode)
        captured.rank_select_n[CRAO_CHIP_ID_LSB-1:0] = 2'h3; // Id bits still pass [R7]
      else
        captured.rank_select_n = CRAO_RANK_IDLE;       // No select without valid command [R1]
    end
    nxt_state           = state_ff;
    nxt_state.rst_out_n = module_reset_input_n;          // Clocked copy of reset [R5]
    // Delay line from capture to output [R6]
    nxt_state.pipe[0]   = captured;
    for (int i = 1; i < LATENCY; i++)
    begin
      nxt_state.pipe[i] = state_ff.pipe[i-1];
    end
    nxt_state.drive_en  = 1'b1;
    // Alert from input error or enabled parity check [R3] [R4] [R9]
    nxt_state.alert_oe  = !error_in_n || (parity_enable && in_valid && in_par_bad);
    // Reset input clears latches and floats outputs [R10]
    if (!module_reset_input_n)
    begin
      for (int i = 0; i < LATENCY; i++)
      begin
        nxt_state.pipe[i] = CRAO_CA_RESET;
      end
      nxt_state.drive_en = 1'b0;
      nxt_state.alert_oe = 1'b0;
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_ff.pipe      <= {LATENCY{CRAO_CA_RESET}};
      state_ff.drive_en  <= 1'b0;
      state_ff.rst_out_n <= 1'b0;
      state_ff.alert_oe  <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  // Both copies from the same last stage [R11]
  assign side_a_bus              = state_ff.pipe[LATENCY-1];
  assign side_b_bus              = state_ff.pipe[LATENCY-1];
  assign bus_drive_en            = state_ff.drive_en;
  assign redriven_module_reset_n = state_ff.rst_out_n;
  assign alert_oe                = state_ff.alert_oe;
  assign alert_out               = 1'b0;              // Open drain only ever pulls low

  // ****************************************************************
  // Assertions
  // ****************************************************************
  logic [3:0] up_cnt_ff;   // Cycles since reset input went high, saturating

  always_ff @(posedge clk)
  begin
    if (rst || !module_reset_input_n)
      up_cnt_ff <= 4'h0;
    else if (up_cnt_ff != 4'hf)
      up_cnt_ff <= up_cnt_ff + 4'h1;
  end

  // Mode that applied at capture decides which selects count, for any latency
  property p_one_select;
    @(posedge clk) disable iff (rst)
    $past(chip_id_mode, LATENCY) ? ($countones(~side_a_bus.rank_select_n[CRAO_CHIP_ID_LSB-1:0]) <= 1)
      : ($countones(~side_a_bus.rank_select_n) <= 1);
  endproperty
  a_one_select: assert property (p_one_select) else $error("More than one select low"); // [R1]

  property p_strobes;
    @(posedge clk) disable iff (rst)
    (up_cnt_ff > 4'(LATENCY)) && !side_a_bus.activate_n |->
      side_a_bus.addr[CRAO_ROW_STROBE_BIT:CRAO_WRITE_STROBE_BIT] == $past(ca_in.addr[16:14], LATENCY);
  endproperty
  a_strobes: assert property (p_strobes) else $error("Activate strobes not carried"); // [R2]

  property p_parity_alert;
    @(posedge clk) disable iff (rst)
    parity_enable && module_reset_input_n && crao_cmd_valid(ca_in.rank_select_n, chip_id_mode)
      && crao_parity_bad(ca_in) |=> alert_oe;
  endproperty
  a_parity_alert: assert property (p_parity_alert) else $error("Parity error not alerted"); // [R3]

  property p_error_alert;
    @(posedge clk) disable iff (rst)
    !error_in_n && module_reset_input_n |=> alert_oe && !alert_out;
  endproperty
  a_error_alert: assert property (p_error_alert) else $error("Error input not alerted"); // [R4]

  property p_no_false_alert;
    @(posedge clk) disable iff (rst)
    ##1 alert_oe |-> $past(!error_in_n) || ($past(parity_enable) && $past(crao_parity_bad(ca_in)));
  endproperty
  a_no_false_alert: assert property (p_no_false_alert) else $error("Alert without cause"); // [R9]

  property p_reset_out;
    @(posedge clk) disable iff (rst)
    ##1 redriven_module_reset_n == $past(module_reset_input_n);
  endproperty
  a_reset_out: assert property (p_reset_out) else $error("Re-driven reset not one cycle late"); // [R5]

  property p_latency;
    @(posedge clk) disable iff (rst)
    up_cnt_ff > 4'(LATENCY) |-> side_a_bus.addr == $past(ca_in.addr, LATENCY)
      && side_a_bus.bank == $past(ca_in.bank, LATENCY) && side_a_bus.parity == $past(ca_in.parity, LATENCY);
  endproperty
  a_latency: assert property (p_latency) else $error("Output not valid after latency"); // [R6]

  property p_chip_id;
    @(posedge clk) disable iff (rst)
    up_cnt_ff > 4'(LATENCY) && $past(chip_id_mode, LATENCY) |->
      side_a_bus.rank_select_n[3:2] == $past(ca_in.rank_select_n[3:2], LATENCY);
  endproperty
  a_chip_id: assert property (p_chip_id) else $error("Chip id bits not carried"); // [R7]

  property p_float;
    @(posedge clk) disable iff (rst)
    !module_reset_input_n |=> !bus_drive_en && !alert_oe && side_a_bus.rank_select_n == CRAO_RANK_IDLE;
  endproperty
  a_float: assert property (p_float) else $error("Outputs not floated in reset"); // [R10]

  property p_copies;
    @(posedge clk) disable iff (rst)
    side_a_bus == side_b_bus;
  endproperty
  a_copies: assert property (p_copies) else $error("Output copies differ"); // [R11]

  c_activate: cover property (@(posedge clk) disable iff (rst) bus_drive_en && !side_a_bus.activate_n);
  c_parity: cover property (@(posedge clk) disable iff (rst) parity_enable ##1 alert_oe);
  c_chip_id: cover property (@(posedge clk) disable iff (rst) chip_id_mode && bus_drive_en);
  c_float: cover property (@(posedge clk) disable iff (rst) !module_reset_input_n ##1 module_reset_input_n);

endmodule

// ==== crao_dram_model.sv ====
// Partner model: DRAM rank taking the re-driven bus and raising the error line
`timescale 1ns/1ps
module crao_dram_model
  import crao_pkg::*;
(
  // Clock
  input  wire logic     clk,
  // Re-driven bus
  input  wire crao_ca_t side_a_bus,
  input  wire logic     bus_drive_en,
  // Error line
  input  wire logic     err_req,
  output logic          error_in_n,
  output crao_ca_t      rx_word
);
  // Open drain, pulled up when released
  assign error_in_n = err_req ? 1'b0 : 1'b1;

  // Take a word only when driven with one select low
  always_ff @(posedge clk)
  begin
    if (bus_drive_en && $countones(~side_a_bus.rank_select_n) == 1)
    begin
      rx_word <= side_a_bus;
    end
  end
endmodule

// ==== crao_output_stage_tb.sv ====
// Testbench: self-checking scenarios for the command/address output stage
`timescale 1ns/1ps
module crao_output_stage_tb
  import crao_pkg::*;
;
  // ****************************************************************
  // Stimulus, partner and checks
  // ****************************************************************
  logic     clk = 1'b0;
  logic     rst = 1'b1;
  logic     parity_enable = 1'b0;
  logic     chip_id_mode = 1'b0;
  logic     module_reset_input_n = 1'b0;
  logic     err_req = 1'b0;
  crao_ca_t ca_in = CRAO_CA_RESET;
  crao_ca_t side_a_bus, side_b_bus, rx_word;
  logic     bus_drive_en, redriven_module_reset_n, alert_out, alert_oe, error_in_n, alert_wire;
  int       failures = 0;
  int       n_checks = 0;
  int       cycles = 0;

  // Clock and open-drain alert pin with pull-up
  always #10 clk = ~clk;
  assign alert_wire = alert_oe ? alert_out : 1'b1;

  crao_output_stage #(.LATENCY(1)) dut (.clk(clk), .rst(rst), .parity_enable(parity_enable),
    .chip_id_mode(chip_id_mode), .ca_in(ca_in), .module_reset_input_n(module_reset_input_n),
    .error_in_n(error_in_n), .side_a_bus(side_a_bus), .side_b_bus(side_b_bus),
    .bus_drive_en(bus_drive_en), .redriven_module_reset_n(redriven_module_reset_n),
    .alert_out(alert_out), .alert_oe(alert_oe));
  crao_dram_model dram (.clk(clk), .side_a_bus(side_a_bus), .bus_drive_en(bus_drive_en),
    .err_req(err_req), .error_in_n(error_in_n), .rx_word(rx_word));

  task automatic complete_run;
    if (failures == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask

  // Word builder, bad flips the parity bit
  function automatic crao_ca_t mk(input logic [3:0] rs, input logic act, input logic [17:0] a,
                                  input logic bad);
    crao_ca_t w;
    w = '{rank_select_n: rs, chip_id2: 1'b1, addr: a, bank: 2'h1, bank_group: 2'h2,
          activate_n: act, clock_enable: 2'h3, termination: 2'h1, parity: 1'b0};
    w.parity = ^{w.addr, w.bank, w.bank_group, w.activate_n} ^ bad;
    return w;
  endfunction

  // One word in, one edge on
  task automatic step(input crao_ca_t w);
    ca_in = w;
    @(posedge clk);
    #1;
  endtask

  task automatic t_activate;
    crao_ca_t w;
    crao_ca_t w2;
    w = mk(4'he, 1'b0, 18'h1c123, 1'b0);
    w2 = mk(4'hb, 1'b1, 18'h2a5a5, 1'b0);
    step(w);
    chk(side_a_bus, w);
    chk(side_b_bus, w);
    step(w2);
    chk(side_a_bus, w2);
    chk(side_b_bus, w2);
    chk(rx_word, w);
  endtask

  task automatic t_select;
    crao_ca_t w;
    w = mk(4'hc, 1'b1, 18'h00400, 1'b0);
    step(w);
    w.rank_select_n = 4'hf;
    chk(side_a_bus, w);
    w = mk(4'h0, 1'b0, 18'h3ffff, 1'b0);
    step(w);
    w.rank_select_n = 4'hf;
    chk(side_b_bus, w);
  endtask

  task automatic t_chip_id;
    crao_ca_t w;
    chip_id_mode = 1'b1;
    w = mk(4'h9, 1'b1, 18'h01234, 1'b0);
    step(w);
    chk(side_a_bus, w);
    w = mk(4'h4, 1'b1, 18'h01234, 1'b0);
    step(w);
    w.rank_select_n = 4'h7;
    chk(side_b_bus, w);
    chip_id_mode = 1'b0;
  endtask

  task automatic t_parity;
    parity_enable = 1'b1;
    step(mk(4'hd, 1'b1, 18'h00f0f, 1'b1));
    chk(alert_wire, 1'b0);
    step(mk(4'hd, 1'b1, 18'h00f0f, 1'b0));
    chk(alert_wire, 1'b1);
    parity_enable = 1'b0;
    step(mk(4'hd, 1'b1, 18'h00f0f, 1'b1));
    chk(alert_wire, 1'b1);
  endtask

  task automatic t_error;
    err_req = 1'b1;
    step(CRAO_CA_RESET);
    chk(alert_wire, 1'b0);
    parity_enable = 1'b1;
    step(CRAO_CA_RESET);
    chk(alert_wire, 1'b0);
    err_req = 1'b0;
    parity_enable = 1'b0;
    step(CRAO_CA_RESET);
    chk(alert_wire, 1'b1);
  endtask

  task automatic t_module_reset;
    module_reset_input_n = 1'b0;
    chk(redriven_module_reset_n, 1'b1);
    step(mk(4'he, 1'b1, 18'h00001, 1'b0));
    chk(redriven_module_reset_n, 1'b0);
    chk(bus_drive_en, 1'b0);
    step(mk(4'he, 1'b1, 18'h00001, 1'b0));
    chk(bus_drive_en, 1'b0);
    chk(side_a_bus, CRAO_CA_RESET);
    chk(redriven_module_reset_n, 1'b0);
    module_reset_input_n = 1'b1;
    chk(redriven_module_reset_n, 1'b0);
    step(CRAO_CA_RESET);
    chk(redriven_module_reset_n, 1'b1);
    chk(bus_drive_en, 1'b1);
    step(CRAO_CA_RESET);
    chk(bus_drive_en, 1'b1);
    chk(redriven_module_reset_n, 1'b1);
  endtask

  // Cycle ceiling against hangs
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      failures++;
      complete_run;
    end
  end

  // Main sequence
  initial
  begin
    repeat (8) @(posedge clk);
    #1;
    chk(bus_drive_en, 1'b0);
    chk(side_a_bus, CRAO_CA_RESET);
    chk(redriven_module_reset_n, 1'b0);
    rst = 1'b0;
    module_reset_input_n = 1'b1;
    step(CRAO_CA_RESET);
    step(CRAO_CA_RESET);
    chk(bus_drive_en, 1'b1);
    t_activate;
    t_select;
    t_chip_id;
    t_parity;
    t_error;
    t_module_reset;
    complete_run;
  end
endmodule
